// File: rtl/als_prox_regs.sv
/*
 * register bank and measurement sequencer of a light and proximity sensor,
 * reached over a two-wire serial slave.
 * assumes scl and sda come straight from pins; converter counts come from
 * logic on clk and are sampled when a measurement ends.
 */
// What this block does
// [RULE1] enable bit 3 turns on wait period
// [RULE2] enable bit 2 turns on proximity measurement
// [RULE3] enable bit 1 turns on light measurement
// [RULE4] enable bit 0 powers oscillator; else inactive
// [RULE5] host sets light enable with power-on together
// [RULE6] host programs setup before enabling a mode
// [RULE7] integration down counter ends at zero
// [RULE8] integration lasts register plus one steps
// [RULE9] integration clock is oscillator divided by 11
// [RULE10] one step is 2048 integration clocks
// [RULE11] visible result at 0x94/0x95, read-only
// [RULE12] infrared result at 0x96/0x97, read-only
// [RULE13] proximity result at 0x9C, read-only
// [RULE14] light low threshold at 0x84/0x85
// [RULE15] light high threshold at 0x86/0x87
// [RULE16] proximity thresholds at 0x88 and 0x8A
// [RULE17] proximity offset magnitude 0xC0, sign 0xC1
// [RULE18] light maximum grows 1024 per step, saturates
// [RULE19] host writes zeros to reserved enable bits
// [RULE20] reset to sleep, power-on moves to idle
// [RULE21] threshold low byte buffered until high byte
// [RULE22] proximity sample lasts register plus one times 88us
// [RULE23] long wait multiplies wait by 12
`timescale 1ns/1ps
`default_nettype none

module als_prox_regs
	import als_prox_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h39,
	parameter int STEP_LEN = als_prox_pkg::STEP_ICLKS,
	parameter int ICLK_LEN = als_prox_pkg::ICLK_CYCLES,
	parameter int PROX_LEN = als_prox_pkg::PROX_STEP_CYCLES,
	parameter logic [7:0] REVISION_VAL = 8'h5A, // arbitrary value
	parameter logic [7:0] PART_VAL = 8'hA5, // arbitrary value
	parameter logic [7:0] AUX_VAL = 8'h3C // arbitrary value
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// two-wire serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// converter counts
	input wire logic [15:0] vis_count,
	input wire logic [15:0] ir_count,
	input wire logic [7:0] prox_count,
	// activity
	output logic osc_on,
	output logic light_busy,
	output logic prox_busy,
	output logic wait_busy
);
	import als_prox_pkg::*;

	// ****************************************
	// checks and types
	// ****************************************
	if (STEP_LEN < 1 || STEP_LEN > 2048 || ICLK_LEN < 1 || ICLK_LEN > 63
		|| PROX_LEN < 1 || PROX_LEN > 4095)
	begin : g_bad_param
		$error("timing parameter out of range");
	end

	typedef enum logic [2:0] {S_SLEEP, S_IDLE, S_PROX, S_LIGHT, S_WAIT} seq_t;
	typedef enum logic [2:0] {I_IDLE, I_RECV, I_ACK, I_SEND, I_MACK} ser_t;

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_prev;
		logic sda_prev;
		ser_t ser;
		logic [1:0] kind; // 0 address, 1 register pointer, 2 data
		logic rd;
		logic mack;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic sda_oe;
		logic [NUM_RW-1:0][7:0] rw_regs;
		logic [7:0] llt_buf;
		logic [7:0] lht_buf;
		logic [15:0] llt;
		logic [15:0] lht;
		logic [15:0] vis;
		logic [15:0] ir;
		logic [7:0] prox;
		logic lvalid;
		logic pvalid;
		seq_t seq;
		logic [5:0] div;
		logic [10:0] icnt;
		logic [7:0] steps;
		logic [3:0] longcnt;
		logic [11:0] pcyc;
		logic osc_on;
		logic light_busy;
		logic prox_busy;
		logic wait_busy;
	} state_t;

	state_t q;
	state_t n;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] rd_data;
	logic scl_rise;
	logic scl_fall;
	logic step_end;
	logic [7:0] light_integration_time;
	logic [7:0] enable;

	assign enable = q.rw_regs[IDX_ENABLE];
	assign light_integration_time = q.rw_regs[IDX_LIGHT_TIME];

	// ****************************************
	// read mux
	// ****************************************
	// read path is one lookup on the auto-incrementing pointer
	always_comb
	begin
		rd_data = 8'h00;
		for (int i = 0; i < NUM_RW; i++)
		begin
			if (q.ptr == RW_ADDR[i])
			begin
				rd_data = q.rw_regs[i]; // [RULE16] [RULE17]
			end
		end
		case (q.ptr)
			ADDR_LLT_LO: rd_data = q.llt[7:0]; // [RULE14]
			ADDR_LLT_HI: rd_data = q.llt[15:8]; // [RULE14]
			ADDR_LHT_LO: rd_data = q.lht[7:0]; // [RULE15]
			ADDR_LHT_HI: rd_data = q.lht[15:8]; // [RULE15]
			ADDR_REVISION: rd_data = REVISION_VAL;
			ADDR_PART: rd_data = PART_VAL;
			ADDR_STATUS: rd_data = {6'h00, q.pvalid, q.lvalid};
			ADDR_VIS_LO: rd_data = q.vis[7:0]; // [RULE11]
			ADDR_VIS_HI: rd_data = q.vis[15:8]; // [RULE11]
			ADDR_IR_LO: rd_data = q.ir[7:0]; // [RULE12]
			ADDR_IR_HI: rd_data = q.ir[15:8]; // [RULE12]
			ADDR_PROX_RES: rd_data = q.prox; // [RULE13]
			ADDR_AUX: rd_data = AUX_VAL;
			default: ;
		endcase
	end

	// ****************************************
	// next state
	// ****************************************
	// edges read only the second sync stage and its delayed copy
	assign scl_rise = q.scl_s[1] && !q.scl_prev;
	assign scl_fall = !q.scl_s[1] && q.scl_prev;
	// step is 2048 integration clocks, each one eleven oscillator periods
	assign step_end = (q.div == 6'(ICLK_LEN - 1)) // [RULE9]
		&& (q.icnt == 11'(STEP_LEN - 1)); // [RULE10]

	always_comb
	begin
		logic [15:0] sat;
		sat = 16'h0000;
		n = q;
		wr_en = 1'b0;
		wr_addr = q.ptr;
		n.scl_s = {q.scl_s[0], scl_in};
		n.sda_s = {q.sda_s[0], sda_in};
		n.scl_prev = q.scl_s[1];
		n.sda_prev = q.sda_s[1];

		// serial slave: start and stop win over any byte in progress
		if (q.scl_s[1] && q.scl_prev && q.sda_prev && !q.sda_s[1])
		begin
			n.ser = I_RECV;
			n.kind = 2'd0;
			n.bitcnt = 4'h0;
			n.sda_oe = 1'b0;
		end
		else if (q.scl_s[1] && q.scl_prev && !q.sda_prev && q.sda_s[1])
		begin
			n.ser = I_IDLE;
			n.sda_oe = 1'b0;
		end
		else
		begin
			case (q.ser)
				I_RECV:
				begin
					if (scl_rise)
					begin
						n.shreg = {q.shreg[6:0], q.sda_s[1]};
						n.bitcnt = q.bitcnt + 4'h1;
					end
					else if (scl_fall && q.bitcnt == 4'h8)
					begin
						n.ser = I_ACK;
						n.sda_oe = 1'b1;
						if (q.kind == 2'd0)
						begin
							n.rd = q.shreg[0];
							if (q.shreg[7:1] != DEV_ADDR)
							begin
								n.ser = I_IDLE;
								n.sda_oe = 1'b0;
							end
						end
						else if (q.kind == 2'd1)
						begin
							n.ptr = q.shreg;
						end
						else
						begin
							wr_en = 1'b1;
							n.ptr = q.ptr + 8'h01;
						end
					end
				end
				I_ACK:
				begin
					if (scl_fall)
					begin
						n.bitcnt = 4'h0;
						n.sda_oe = 1'b0;
						if (q.rd && q.kind == 2'd0)
						begin
							n.ser = I_SEND;
							n.shreg = rd_data;
							n.sda_oe = !rd_data[7];
							n.ptr = q.ptr + 8'h01;
						end
						else
						begin
							n.ser = I_RECV;
							n.kind = (q.kind == 2'd0) ? 2'd1 : 2'd2;
						end
					end
				end
				I_SEND:
				begin
					if (scl_rise)
					begin
						n.bitcnt = q.bitcnt + 4'h1;
					end
					else if (scl_fall && q.bitcnt == 4'h8)
					begin
						n.ser = I_MACK;
						n.sda_oe = 1'b0;
					end
					else if (scl_fall)
					begin
						n.shreg = {q.shreg[6:0], 1'b0};
						n.sda_oe = !q.shreg[6];
					end
				end
				I_MACK:
				begin
					if (scl_rise)
					begin
						n.mack = !q.sda_s[1];
					end
					else if (scl_fall && q.mack)
					begin
						n.ser = I_SEND;
						n.bitcnt = 4'h0;
						n.shreg = rd_data;
						n.sda_oe = !rd_data[7];
						n.ptr = q.ptr + 8'h01;
					end
					else if (scl_fall)
					begin
						n.ser = I_IDLE;
					end
				end
				default: n.ser = I_IDLE;
			endcase
		end

		// register writes; low threshold bytes wait for their high byte
		if (wr_en)
		begin
			for (int i = 0; i < NUM_RW; i++)
			begin
				if (wr_addr == RW_ADDR[i])
				begin
					n.rw_regs[i] = q.shreg; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE16] [RULE17]
				end
			end
			case (wr_addr)
				ADDR_LLT_LO: n.llt_buf = q.shreg; // [RULE21]
				ADDR_LLT_HI: n.llt = {q.shreg, q.llt_buf}; // [RULE14] [RULE21]
				ADDR_LHT_LO: n.lht_buf = q.shreg; // [RULE21]
				ADDR_LHT_HI: n.lht = {q.shreg, q.lht_buf}; // [RULE15] [RULE21]
				default: ;
			endcase
		end

		// measurement sequencer, stepped from the current enable bits
		sat = (light_integration_time > SAT_STEP) ? 16'hFFFF : {light_integration_time[5:0], 10'h3FF}; // [RULE18]
		if (q.seq != S_LIGHT && q.seq != S_WAIT)
		begin
			n.div = 6'h00;
			n.icnt = 11'h000;
		end
		else if (q.div == 6'(ICLK_LEN - 1))
		begin
			n.div = 6'h00;
			n.icnt = step_end ? 11'h000 : q.icnt + 11'h001; // [RULE10]
		end
		else
		begin
			n.div = q.div + 6'h01; // [RULE9]
		end
		case (q.seq)
			S_SLEEP:
			begin
				if (enable[BIT_POWER_ON])
				begin
					n.seq = S_IDLE; // [RULE20]
				end
			end
			S_IDLE:
			begin
				n.pcyc = 12'h000;
				n.longcnt = 4'h0;
				if (enable[BIT_PROX_EN])
				begin
					n.seq = S_PROX; // [RULE2]
					n.steps = q.rw_regs[IDX_PROX_TIME];
				end
				else if (enable[BIT_LIGHT_EN])
				begin
					n.seq = S_LIGHT; // [RULE3]
					n.steps = light_integration_time; // [RULE7]
				end
			end
			S_PROX:
			begin
				n.pcyc = q.pcyc + 12'h001;
				if (q.pcyc == 12'(PROX_LEN - 1))
				begin
					n.pcyc = 12'h000;
					n.steps = q.steps - 8'h01;
					if (q.steps == 8'h00)
					begin
						n.prox = prox_count; // [RULE22]
						n.pvalid = 1'b1;
						n.seq = enable[BIT_LIGHT_EN] ? S_LIGHT
							: (enable[BIT_WAIT_EN] ? S_WAIT : S_IDLE);
						n.steps = enable[BIT_LIGHT_EN] ? light_integration_time : q.rw_regs[IDX_WAIT_TIME];
					end
				end
			end
			S_LIGHT:
			begin
				if (step_end)
				begin
					n.steps = q.steps - 8'h01; // [RULE7]
					if (q.steps == 8'h00)
					begin
						n.vis = (vis_count > sat) ? sat : vis_count; // [RULE8] [RULE18]
						n.ir = (ir_count > sat) ? sat : ir_count; // [RULE18]
						n.lvalid = 1'b1;
						n.seq = enable[BIT_WAIT_EN] ? S_WAIT : S_IDLE; // [RULE1]
						n.steps = q.rw_regs[IDX_WAIT_TIME];
					end
				end
			end
			S_WAIT:
			begin
				if (step_end)
				begin
					// long wait repeats each step twelve times over
					if (q.rw_regs[IDX_SETUP_ZERO][BIT_LONG_WAIT]
						&& q.longcnt != 4'(LONG_WAIT_FACTOR - 1))
					begin
						n.longcnt = q.longcnt + 4'h1; // [RULE23]
					end
					else
					begin
						n.longcnt = 4'h0;
						n.steps = q.steps - 8'h01;
						if (q.steps == 8'h00)
						begin
							n.seq = S_IDLE;
						end
					end
				end
			end
			default: n.seq = S_SLEEP;
		endcase
		// power-off beats everything; results lose their valid flags
		if (!enable[BIT_POWER_ON])
		begin
			n.seq = S_SLEEP; // [RULE4] [RULE20]
			n.lvalid = 1'b0;
			n.pvalid = 1'b0;
		end
		n.osc_on = (n.seq != S_SLEEP); // [RULE4]
		n.light_busy = (n.seq == S_LIGHT);
		n.prox_busy = (n.seq == S_PROX);
		n.wait_busy = (n.seq == S_WAIT);
	end

	// ****************************************
	// state register
	// ****************************************
	// lines idle high, so the sync stages reset to one
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			q <= '0;
			q.scl_s <= 2'b11;
			q.sda_s <= 2'b11;
			q.scl_prev <= 1'b1;
			q.sda_prev <= 1'b1;
			q.ser <= I_IDLE;
			q.seq <= S_SLEEP; // [RULE20]
			q.rw_regs <= RW_RESET;
		end
		else
		begin
			q <= n;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = q.sda_oe;
	assign osc_on = q.osc_on;
	assign light_busy = q.light_busy;
	assign prox_busy = q.prox_busy;
	assign wait_busy = q.wait_busy;

	// ****************************************
	// checks
	// ****************************************
	// helper counters for whole-measurement durations
	logic [31:0] light_len;
	logic [31:0] prox_len;
	always_ff @(posedge clk)
	begin
		if (reset || q.seq != S_LIGHT)
		begin
			light_len <= 32'h0000_0001;
		end
		else
		begin
			light_len <= light_len + 32'h0000_0001;
		end
		if (reset || q.seq != S_PROX)
		begin
			prox_len <= 32'h0000_0001;
		end
		else
		begin
			prox_len <= prox_len + 32'h0000_0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// reset itself disables the checks, so look at its falling edge
	a_sleep_after_reset: assert property ( // [RULE20]
		$fell(reset) |-> q.seq == S_SLEEP && !q.osc_on)
		else $error("not asleep after reset");
	a_power_off_sleeps: assert property ( // [RULE4]
		!enable[BIT_POWER_ON] |=> !osc_on && !light_busy && !prox_busy && !wait_busy)
		else $error("active while powered off");
	// busy flags follow the next state, so they rise on the very next edge
	a_light_start: assert property ( // [RULE3]
		q.seq == S_IDLE && enable[1:0] == 2'h3 && !enable[BIT_PROX_EN] |=> light_busy)
		else $error("light did not start");
	a_prox_start: assert property ( // [RULE2]
		q.seq == S_IDLE && enable[BIT_PROX_EN] && enable[BIT_POWER_ON] |=> prox_busy)
		else $error("proximity did not start");
	// an enable write may land on the same edge that enters wait
	a_wait_needs_bit: assert property ( // [RULE1]
		$rose(q.seq == S_WAIT) |-> $past(enable[BIT_WAIT_EN]))
		else $error("wait without wait enable");
	a_light_duration: assert property ( // [RULE7] [RULE8] [RULE10]
		$rose(q.lvalid) |-> $past(light_len)
		== (32'(light_integration_time) + 32'h1) * 32'(STEP_LEN) * 32'(ICLK_LEN))
		else $error("light integration length wrong");
	a_prox_duration: assert property ( // [RULE22]
		$rose(q.pvalid) |-> $past(prox_len)
		== (32'(q.rw_regs[IDX_PROX_TIME]) + 32'h1) * 32'(PROX_LEN))
		else $error("proximity sample length wrong");
	a_light_saturate: assert property ( // [RULE18]
		$rose(q.lvalid) |-> q.vis <= ((light_integration_time > SAT_STEP) ? 16'hFFFF : {light_integration_time[5:0], 10'h3FF}))
		else $error("light result above maximum");
	a_thresh_paired: assert property ( // [RULE21]
		$changed(q.llt) |-> $past(wr_en && wr_addr == ADDR_LLT_HI))
		else $error("threshold changed without high byte");
	a_high_thresh_paired: assert property ( // [RULE21]
		$changed(q.lht) |-> $past(wr_en && wr_addr == ADDR_LHT_HI))
		else $error("high threshold changed without high byte");

	c_light_done: cover property ($rose(q.lvalid));
	c_prox_then_light: cover property (q.seq == S_PROX ##1 q.seq == S_LIGHT);
	c_wait_done: cover property (q.seq == S_WAIT ##1 q.seq == S_IDLE);
	c_read_byte: cover property (q.ser == I_SEND ##[1:400] q.ser == I_MACK);

endmodule

`default_nettype wire

// File: rtl/als_prox_pkg.sv
/*
 * constants for the light and proximity register bank: register offsets,
 * reset values, bit positions and timing counts.
 * assumes a 40 MHz system clock and an 8 MHz nominal sensor oscillator.
 */
package als_prox_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADDR_ENABLE = 8'h80;
	localparam logic [7:0] ADDR_LIGHT_TIME = 8'h81;
	localparam logic [7:0] ADDR_PROX_TIME = 8'h82;
	localparam logic [7:0] ADDR_WAIT_TIME = 8'h83;
	localparam logic [7:0] ADDR_LLT_LO = 8'h84;
	localparam logic [7:0] ADDR_LLT_HI = 8'h85;
	localparam logic [7:0] ADDR_LHT_LO = 8'h86;
	localparam logic [7:0] ADDR_LHT_HI = 8'h87;
	localparam logic [7:0] ADDR_SETUP_ZERO = 8'h8D;
	localparam logic [7:0] ADDR_REVISION = 8'h91;
	localparam logic [7:0] ADDR_PART = 8'h92;
	localparam logic [7:0] ADDR_STATUS = 8'h93;
	localparam logic [7:0] ADDR_VIS_LO = 8'h94;
	localparam logic [7:0] ADDR_VIS_HI = 8'h95;
	localparam logic [7:0] ADDR_IR_LO = 8'h96;
	localparam logic [7:0] ADDR_IR_HI = 8'h97;
	localparam logic [7:0] ADDR_PROX_RES = 8'h9C;
	localparam logic [7:0] ADDR_AUX = 8'h9E;

	// ****************************************
	// plain read-write registers, index 0..3 are enable and the three times
	// ****************************************
	localparam int NUM_RW = 20;
	localparam logic [NUM_RW-1:0][7:0] RW_ADDR = {
		8'hDD, 8'hDC, 8'hD9, 8'hD7, 8'hD6, 8'hC1, 8'hC0, 8'hAB, 8'h9F, 8'h90,
		8'h8F, 8'h8E, 8'h8D, 8'h8C, 8'h8A, 8'h88, 8'h83, 8'h82, 8'h81, 8'h80};
	localparam logic [NUM_RW-1:0][7:0] RW_RESET = {
		8'h00, 8'h00, 8'h50, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h0C, 8'h04, 8'h00,
		8'h80, 8'h4F, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00};
	localparam int IDX_ENABLE = 0;
	localparam int IDX_LIGHT_TIME = 1;
	localparam int IDX_PROX_TIME = 2;
	localparam int IDX_WAIT_TIME = 3;
	localparam int IDX_SETUP_ZERO = 7;

	// ****************************************
	// bit positions
	// ****************************************
	localparam int BIT_POWER_ON = 0;
	localparam int BIT_LIGHT_EN = 1;
	localparam int BIT_PROX_EN = 2;
	localparam int BIT_WAIT_EN = 3;
	localparam int BIT_LONG_WAIT = 2;
	localparam int BIT_LIGHT_VALID = 0;
	localparam int BIT_PROX_VALID = 1;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int OSC_HZ = 8_000_000;
	localparam int OSC_DIV = 11;
	localparam int STEP_ICLKS = 2048;
	localparam int ICLK_CYCLES = CLK_HZ / OSC_HZ * OSC_DIV;
	localparam int PROX_STEP_NS = 88_000;
	localparam int PROX_STEP_CYCLES = PROX_STEP_NS / (1_000_000_000 / CLK_HZ);
	localparam int LONG_WAIT_FACTOR = 12;
	localparam logic [7:0] SAT_STEP = 8'h3F;

endpackage

// File: tb/i2c_host.sv
/*
 * two-wire bus host model: start, stop, byte transfers, register access.
 * assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none

module i2c_host
(
	// clock
	input wire logic clk,
	// bus pins
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// clk per bus phase, kept above the slave's minimum of 8
	localparam int PHASE = 10;
	logic all_acked;

	// ****************************************
	// bus idles released, scl high
	// ****************************************
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
		all_acked = 1'b1;
	end

	// ****************************************
	// bit level; every change lands just after a clk edge
	// ****************************************
	task automatic phase();
		repeat (PHASE) @(posedge clk);
		#1;
	endtask
	// also serves as repeated start: data released before scl rises
	task automatic start();
		sda_low = 1'b0;
		phase();
		scl = 1'b1;
		phase();
		sda_low = 1'b1;
		phase();
		scl = 1'b0;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		phase();
		scl = 1'b1;
		phase();
		sda_low = 1'b0;
		phase();
	endtask
	// ack is sampled at the end of the low phase, well after the slave drives
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_low = ~b[i];
			phase();
			scl = 1'b1;
			phase();
			scl = 1'b0;
		end
		sda_low = 1'b0;
		phase();
		scl = 1'b1;
		ack = ~sda;
		all_acked = all_acked & ack;
		phase();
		scl = 1'b0;
	endtask
	task automatic recv_byte(input logic last, output logic [7:0] b);
		sda_low = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			phase();
			scl = 1'b1;
			phase();
			b[i] = sda;
			scl = 1'b0;
		end
		sda_low = ~last;
		phase();
		scl = 1'b1;
		phase();
		scl = 1'b0;
	endtask

	// ****************************************
	// register access at slave address 0x39
	// ****************************************
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		logic a;
		start();
		send_byte(8'h72, a);
		send_byte(addr, a);
		send_byte(data, a);
		stop();
	endtask
	// pointer set by a write, then repeated start and one byte with nack
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		logic a;
		start();
		send_byte(8'h72, a);
		send_byte(addr, a);
		start();
		send_byte(8'h73, a);
		recv_byte(1'b1, data);
		stop();
	endtask
endmodule

`default_nettype wire

// File: tb/tb.sv
/*
 * self-checking bench for the light and proximity register bank.
 * assumes the host model in i2c_host.sv and shortened timing parameters.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	import als_prox_pkg::*;
	// clk per integration step with the shortened parameters
	localparam int STEP = 4 * 2;
	localparam int PSTEP = 5;
	logic clk, reset, scl, host_low, sda, sda_out, sda_oe;
	logic [15:0] vis_count, ir_count;
	logic [7:0] prox_count;
	logic osc_on, light_busy, prox_busy, wait_busy;
	int err_count, checks, cycles, n;

	// open-drain data line with pull-up
	assign sda = ~(host_low | (sda_oe & ~sda_out));

	// ****************************************
	// device and host
	// ****************************************
	als_prox_regs #(.STEP_LEN(4), .ICLK_LEN(2), .PROX_LEN(PSTEP),
		.REVISION_VAL(8'h11), .PART_VAL(8'h22), .AUX_VAL(8'h33)) uut ( // arbitrary codes
		.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .vis_count(vis_count), .ir_count(ir_count),
		.prox_count(prox_count), .osc_on(osc_on), .light_busy(light_busy),
		.prox_busy(prox_busy), .wait_busy(wait_busy));
	i2c_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

	// ****************************************
	// clock, hang guard, helpers
	// ****************************************
	always #12.5 clk = ~clk;
	// ceiling sits well above the roughly 54k cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 95000)
		begin
			err_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic reg_is(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		host.read_reg(addr, d);
		check($sformatf("reg %h", addr), {8'h00, exp}, {8'h00, d});
	endtask
	function automatic logic busy(input int which);
		logic [2:0] b;
		b = {wait_busy, prox_busy, light_busy};
		return b[which];
	endfunction
	// length of the next complete busy period, never a partial one
	task automatic busy_len(input int which, output int len);
		len = 0;
		for (int i = 0; i < 3000 && busy(which); i++)
			@(negedge clk);
		for (int i = 0; i < 3000 && !busy(which); i++)
			@(negedge clk);
		while (busy(which) && len < 3000)
		begin
			len++;
			@(negedge clk);
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		check("osc_on", 16'h0000, {15'h0000, osc_on});
		for (int i = 0; i < NUM_RW; i++)
			reg_is(RW_ADDR[i], RW_RESET[i]);
		reg_is(ADDR_PART, 8'h22);
		reg_is(ADDR_STATUS, 8'h00);
	endtask
	// low byte stays buffered until its high byte lands
	task automatic t_thresh();
		logic a;
		for (int k = 0; k < 4; k += 2)
		begin
			host.write_reg(ADDR_LLT_LO + 8'(k), 8'h3C);
			reg_is(ADDR_LLT_LO + 8'(k), 8'h00);
			host.write_reg(ADDR_LLT_HI + 8'(k), 8'hC3);
			reg_is(ADDR_LLT_LO + 8'(k), 8'h3C);
			reg_is(ADDR_LLT_HI + 8'(k), 8'hC3);
		end
		host.write_reg(8'h88, 8'h5A);
		host.write_reg(8'h8A, 8'hA5);
		host.write_reg(8'hC0, 8'h7E);
		host.write_reg(8'hC1, 8'h01);
		reg_is(8'h88, 8'h5A);
		reg_is(8'h8A, 8'hA5);
		reg_is(8'hC0, 8'h7E);
		reg_is(8'hC1, 8'h01);
		host.write_reg(ADDR_VIS_HI, 8'hFF);
		host.write_reg(ADDR_IR_LO, 8'hFF);
		host.write_reg(ADDR_PROX_RES, 8'hFF);
		reg_is(ADDR_VIS_HI, 8'h00);
		reg_is(ADDR_IR_LO, 8'h00);
		reg_is(ADDR_PROX_RES, 8'h00);
		reg_is(8'h89, 8'h00);
		check("bus acks", 16'h0001, {15'h0000, host.all_acked});
		host.start();
		host.send_byte(8'h74, a);
		host.stop();
		check("foreign address ack", 16'h0000, {15'h0000, a});
	endtask
	// setup first, then light and power-on in one write, upper bits zero
	task automatic t_light();
		vis_count = 16'hFFFF;
		ir_count = 16'h0456;
		host.write_reg(ADDR_LIGHT_TIME, 8'h01);
		host.write_reg(ADDR_ENABLE, 8'h03);
		busy_len(0, n);
		check("light time", 16'(2 * STEP), 16'(n));
		check("osc_on", 16'h0001, {15'h0000, osc_on});
		check("prox_busy", 16'h0000, {15'h0000, prox_busy});
		reg_is(ADDR_VIS_LO, 8'hFF);
		reg_is(ADDR_VIS_HI, 8'h07);
		reg_is(ADDR_IR_LO, 8'h56);
		reg_is(ADDR_IR_HI, 8'h04);
		reg_is(ADDR_STATUS, 8'h01);
		host.write_reg(ADDR_ENABLE, 8'h00);
		host.write_reg(ADDR_LIGHT_TIME, 8'h3F);
		host.write_reg(ADDR_ENABLE, 8'h03);
		busy_len(0, n);
		check("light time", 16'(64 * STEP), 16'(n));
		reg_is(ADDR_VIS_HI, 8'hFF);
	endtask
	task automatic t_prox();
		prox_count = 8'hA7;
		host.write_reg(ADDR_ENABLE, 8'h00);
		host.write_reg(ADDR_PROX_TIME, 8'h02);
		host.write_reg(ADDR_ENABLE, 8'h05);
		busy_len(1, n);
		check("prox time", 16'(3 * PSTEP), 16'(n));
		check("light_busy", 16'h0000, {15'h0000, light_busy});
		reg_is(ADDR_PROX_RES, 8'hA7);
		reg_is(ADDR_STATUS, 8'h02);
	endtask
	// plain wait, then the same wait stretched by the long option
	task automatic t_wait();
		host.write_reg(ADDR_ENABLE, 8'h00);
		host.write_reg(ADDR_LIGHT_TIME, 8'h00);
		host.write_reg(ADDR_WAIT_TIME, 8'h01);
		host.write_reg(ADDR_ENABLE, 8'h0B);
		busy_len(2, n);
		check("wait time", 16'(2 * STEP), 16'(n));
		host.write_reg(ADDR_ENABLE, 8'h00);
		host.write_reg(ADDR_SETUP_ZERO, 8'h84);
		host.write_reg(ADDR_ENABLE, 8'h0B);
		busy_len(2, n);
		check("long wait time", 16'(2 * STEP * 12), 16'(n));
	endtask
	task automatic t_off();
		host.write_reg(ADDR_ENABLE, 8'h00);
		@(negedge clk);
		check("osc_on", 16'h0000, {15'h0000, osc_on});
		check("busy", 16'h0000, {13'h0000, wait_busy, prox_busy, light_busy});
		reg_is(ADDR_STATUS, 8'h00);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		clk = 1'b0;
		reset = 1'b1;
		vis_count = 16'h0000;
		ir_count = 16'h0000;
		prox_count = 8'h00;
		repeat (20) @(posedge clk);
		#1;
		reset = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		t_reset();
		t_thresh();
		t_light();
		t_prox();
		t_wait();
		t_off();
		stop_test();
	end
endmodule

`default_nettype wire
